// File: adcsq_ctrl.sv
// Register file and conversion sequencer of the eight-input converter.
// What this block does
// RULE_01 - Result bits 9..2 go to register bits 15..8, bits 1..0 to bits 7..6.
// RULE_02 - Bits 5..0 of every result register always read as zero.
// RULE_03 - Channel position 0..3 within its group selects result register A..D.
// RULE_04 - All result registers clear to zero on reset and standby entry.
// RULE_05 - Control/status register clears to zero on reset and standby entry.
// RULE_06 - End flag sets after one single conversion or after a whole scan group.
// RULE_07 - End flag clears only by writing zero after reading it as one.
// RULE_08 - Conversion-end interrupt is requested only while interrupt enable is one.
// RULE_09 - Writing one to start begins conversion; single mode clears it when done.
// RULE_10 - Scan mode converts cyclically until start is cleared or standby entered.
// RULE_11 - Start bit stays one throughout conversion as a busy indication.
// RULE_12 - Mode bit zero selects single mode, one selects scan mode.
// RULE_13 - Software clears start before changing mode, speed or channel.
// RULE_14 - Speed bit zero gives at most 266 states, one at most 134.
// RULE_15 - Single picks channel by value; scan picks group and channel count.
// RULE_16 - Trigger register resets to 7F; bits 6..0 read one, ignore writes.
// RULE_17 - With trigger enabled a falling trigger edge sets start and converts.
// RULE_18 - Upper byte read returns it and copies the lower byte to holding.
// RULE_19 - Lower byte read returns the holding register.
// RULE_20 - Software reads upper byte before lower byte.
// RULE_21 - Result registers are readable any time without stalling.
// RULE_22 - A restarted scan begins again from the group's first channel.
// RULE_23 - Scan conversions after the first take 256 or 128 states.
// RULE_24 - Core gets start pulse and channel; done strobe writes result and advances.
`include "adcsq_defines.svh"

module adcsq_ctrl (
    input  wire logic                      mclk,
    input  wire logic                      srst,
    input  wire logic                      standby,
    input  wire adcsq_pkg::adcsq_bus_req_t bus_req,
    output logic [7:0]                     bus_rdata,
    input  wire logic                      ext_trigger_n,
    output adcsq_pkg::adcsq_core_cmd_t     core_cmd,
    input  wire adcsq_pkg::adcsq_core_rsp_t core_rsp,
    output logic                           conv_end_irq
);
    import adcsq_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_START, ST_WAIT} adcsq_state_t;

    adcsq_state_t state_q;
    logic [15:0]  result_q [4];
    logic [7:0]   hold_q;
    logic         end_flag_q;
    logic         end_seen_q;
    logic         irq_en_q;
    logic         start_q;
    logic         scan_q;
    logic         speed_q;
    logic [2:0]   chsel_q;
    logic         trig_en_q;
    logic         trig_prev_q;
    logic [1:0]   pos_q;
    logic         first_q;
    logic [8:0]   tmr_q;
    logic [7:0]   rdata_q;
    adcsq_core_cmd_t cmd_q;
    logic         irq_q;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    function automatic logic [15:0] pack_result(input logic [9:0] r);
        return {r, 6'h00};
    endfunction : pack_result

    // Soft reset covers both hard reset and standby entry.
    wire        clr       = srst | standby;
    wire        wr_csr    = bus_req.wr && bus_req.addr == `ADCSQ_OFF_CSR;
    wire        wr_trig   = bus_req.wr && bus_req.addr == `ADCSQ_OFF_TRIG;
    wire        rd_csr    = bus_req.rd && bus_req.addr == `ADCSQ_OFF_CSR;
    wire        rd_res    = bus_req.rd && bus_req.addr[3] == 1'b0;
    wire [1:0]  rd_idx    = bus_req.addr[2:1];
    wire        rd_hi     = rd_res && !bus_req.addr[0];
    wire        trig_fall = trig_en_q && trig_prev_q && !ext_trigger_n;      // [RULE_17]
    wire        sw_start  = wr_csr && bus_req.wdata[`ADCSQ_CSR_START] && !start_q;
    wire        go        = !start_q && (sw_start || trig_fall);             // [RULE_09]
    wire        sw_stop   = wr_csr && !bus_req.wdata[`ADCSQ_CSR_START];      // [RULE_10]
    wire        done      = state_q == ST_WAIT && core_rsp.done;
    wire [1:0]  last_pos  = scan_q ? chsel_q[1:0] : 2'h0;                    // [RULE_15]
    wire        grp_done  = done && pos_q == last_pos;
    wire [1:0]  reg_idx   = scan_q ? pos_q : chsel_q[1:0];                   // [RULE_03]
    wire [2:0]  conv_ch   = scan_q ? {chsel_q[2], pos_q} : chsel_q;          // [RULE_15]
    // Speed picks the budget; only the first conversion after each start gets the longer one.
    wire [8:0]  budget    = first_q ? (speed_q ? `ADCSQ_FIRST_FAST : `ADCSQ_FIRST_SLOW)
                                    : (speed_q ? `ADCSQ_NEXT_FAST : `ADCSQ_NEXT_SLOW); // [RULE_14] [RULE_23]
    wire [7:0]  csr_view  = {end_flag_q, irq_en_q, start_q, scan_q, speed_q, chsel_q};
    wire [7:0]  rd_mux    = rd_csr ? csr_view :
                            (bus_req.rd && bus_req.addr == `ADCSQ_OFF_TRIG) ? {trig_en_q, 7'h7F} : // [RULE_16]
                            rd_hi ? result_q[rd_idx][15:8] :                 // [RULE_18] [RULE_21]
                            rd_res ? hold_q : 8'h00;                         // [RULE_19]
    wire        end_set   = grp_done;                                        // [RULE_06]
    wire        end_clr   = wr_csr && end_seen_q && !bus_req.wdata[`ADCSQ_CSR_END]; // [RULE_07]

    // ------------------------------------------------------------------
    // Control/status and trigger registers
    // ------------------------------------------------------------------
    // The set wins over a clear in the same cycle, so no completion is lost.
    always_ff @(posedge mclk) begin
        if (clr) begin                                                       // [RULE_05] [RULE_16]
            end_flag_q <= 1'b0;
            end_seen_q <= 1'b0;
            irq_en_q   <= 1'b0;
            scan_q     <= 1'b0;                                              // [RULE_12]
            speed_q    <= 1'b0;
            chsel_q    <= 3'h0;
            trig_en_q  <= 1'b0;
        end else begin
            end_flag_q <= end_set | (end_flag_q & ~end_clr);
            if (rd_csr) begin
                end_seen_q <= end_flag_q;
            end else if (wr_csr) begin
                end_seen_q <= 1'b0;
            end
            if (wr_csr) begin
                irq_en_q <= bus_req.wdata[`ADCSQ_CSR_IE];
                scan_q   <= bus_req.wdata[`ADCSQ_CSR_SCAN];
                speed_q  <= bus_req.wdata[`ADCSQ_CSR_SPEED];
                chsel_q  <= bus_req.wdata[`ADCSQ_CSR_GROUP:0];
            end
            if (wr_trig) begin
                trig_en_q <= bus_req.wdata[`ADCSQ_TRIG_EN];
            end
        end
    end

    // Previous trigger level; reset high, but trig_en_q is clear at release, so a pin already low then never reads as a falling edge.
    always_ff @(posedge mclk) begin
        if (srst) begin
            trig_prev_q <= 1'b1;
        end else begin
            trig_prev_q <= ext_trigger_n;
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // Start stays set while busy; single mode drops it at the one result.
    always_ff @(posedge mclk) begin
        if (clr) begin
            state_q <= ST_IDLE;
            start_q <= 1'b0;
            pos_q   <= 2'h0;
            first_q <= 1'b1;
            tmr_q   <= 9'h000;
            cmd_q   <= '0;
        end else begin
            cmd_q.start <= 1'b0;
            if (go) begin                                                    // [RULE_11] [RULE_22]
                start_q       <= 1'b1;
                pos_q         <= 2'h0;
                first_q       <= 1'b1;
                state_q       <= ST_START;
            end else if (start_q && sw_stop) begin                           // [RULE_10]
                start_q <= 1'b0;
                state_q <= ST_IDLE;
            end else begin
                unique case (state_q)
                    ST_IDLE: begin
                    end
                    ST_START: begin                                          // [RULE_24]
                        cmd_q.start   <= 1'b1;
                        cmd_q.channel <= conv_ch;
                        tmr_q         <= budget - 9'd1;
                        state_q       <= ST_WAIT;
                    end
                    ST_WAIT: begin
                        if (tmr_q != 9'h000) begin
                            tmr_q <= tmr_q - 9'd1;
                        end
                        if (done) begin
                            first_q <= 1'b0;
                            if (!scan_q) begin                               // [RULE_09]
                                start_q <= 1'b0;
                                state_q <= ST_IDLE;
                            end else begin                                   // [RULE_10]
                                pos_q   <= grp_done ? 2'h0 : pos_q + 2'd1;
                                state_q <= ST_START;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Result registers and holding byte
    // ------------------------------------------------------------------
    // Reads never stall; the holding byte is only loaded by an upper read.
    always_ff @(posedge mclk) begin
        if (clr) begin                                                       // [RULE_04]
            for (int i = 0; i < 4; i++) begin
                result_q[i] <= `ADCSQ_RES_RESET;
            end
            hold_q <= 8'h00;
        end else begin
            if (done) begin
                result_q[reg_idx] <= pack_result(core_rsp.result);           // [RULE_01] [RULE_02] [RULE_03]
            end
            if (rd_hi) begin
                hold_q <= result_q[rd_idx][7:0];                             // [RULE_18]
            end
        end
    end

    // Registered outputs.
    always_ff @(posedge mclk) begin
        if (srst) begin
            rdata_q <= 8'h00;
            irq_q   <= 1'b0;
        end else begin
            rdata_q <= rd_mux;
            irq_q   <= end_flag_q & irq_en_q & ~standby;                     // [RULE_08]
        end
    end

    assign bus_rdata    = rdata_q;
    assign core_cmd     = cmd_q;
    assign conv_end_irq = irq_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_irq_gated: assert property (@(posedge mclk) disable iff (srst)
        conv_end_irq |-> $past(irq_en_q) && $past(end_flag_q))               // [RULE_08]
        else $error("Interrupt raised while disabled or flag clear.");
    a_result_low_zero: assert property (@(posedge mclk) disable iff (srst)
        result_q[0][5:0] == 6'h00 && result_q[3][5:0] == 6'h00)              // [RULE_02]
        else $error("Reserved result bits not zero.");
    a_single_ends_start: assert property (@(posedge mclk) disable iff (clr)
        done && !scan_q && !go |=> !start_q && end_flag_q)                   // [RULE_09]
        else $error("Single conversion did not end cleanly.");
    a_start_busy: assert property (@(posedge mclk) disable iff (srst)
        state_q != ST_IDLE |-> start_q)                                      // [RULE_11]
        else $error("Busy without start bit.");
    a_end_write_one: assert property (@(posedge mclk) disable iff (clr)
        end_flag_q && wr_csr && bus_req.wdata[7] |=> end_flag_q)            // [RULE_07]
        else $error("Writing one cleared the end flag.");
    a_trig_start: assert property (@(posedge mclk) disable iff (clr)
        trig_fall && !start_q |=> start_q ##1 cmd_q.start)                   // [RULE_17]
        else $error("Trigger edge did not start conversion.");
    a_hold_load: assert property (@(posedge mclk) disable iff (clr)
        rd_hi && !done |=> hold_q == $past(result_q[rd_idx][7:0]))           // [RULE_18]
        else $error("Holding byte not loaded.");
    a_scan_restart: assert property (@(posedge mclk) disable iff (clr)
        go && scan_q |=> ##1 cmd_q.channel[1:0] == 2'h0)                     // [RULE_22]
        else $error("Scan restart not at first channel.");

    // ------------------------------------------------------------------
    // Register and sequencer checks
    // ------------------------------------------------------------------
    // Reserved trigger bits must read as ones whatever was written.
    a_trig_ro: assert property (@(posedge mclk) disable iff (srst)           // [RULE_16]
        bus_req.rd && bus_req.addr == `ADCSQ_OFF_TRIG |=> bus_rdata[6:0] == 7'h7F)
        else $error("Reserved trigger bits not read as one.");
    // Standby must leave the control bits exactly as a hard reset does.
    a_csr_reset: assert property (@(posedge mclk)                            // [RULE_05]
        clr |=> csr_view == 8'h00 && trig_en_q == 1'b0)
        else $error("Control register not cleared.");
    // All four results go back to zero, not only the one last written.
    a_res_reset: assert property (@(posedge mclk)                            // [RULE_04]
        clr |=> {result_q[0], result_q[1], result_q[2], result_q[3]} == 64'h0)
        else $error("Result registers not cleared.");
    // The middle registers carry the same reserved field as the outer ones.
    a_result_mid_zero: assert property (@(posedge mclk) disable iff (srst)   // [RULE_02]
        result_q[1][5:0] == 6'h00 && result_q[2][5:0] == 6'h00)
        else $error("Reserved result bits not zero.");
    // A single conversion ends the job, so the flag must follow at once.
    a_single_set_end: assert property (@(posedge mclk) disable iff (clr)     // [RULE_06]
        done && !scan_q |=> end_flag_q)
        else $error("Single conversion did not set the end flag.");
    // Mid-group results must not raise the flag early.
    a_scan_no_early: assert property (@(posedge mclk) disable iff (clr)      // [RULE_06]
        done && scan_q && !grp_done && !end_flag_q |=> !end_flag_q)
        else $error("End flag set before the group finished.");
    // Without a prior read that saw the flag, a zero write must not clear it.
    a_end_clr_seen: assert property (@(posedge mclk) disable iff (clr)       // [RULE_07]
        end_flag_q && !end_seen_q |=> end_flag_q)
        else $error("End flag cleared without a read.");
    // An enabled, raised flag must reach the interrupt output one cycle later.
    a_irq_follow: assert property (@(posedge mclk) disable iff (srst)        // [RULE_08]
        end_flag_q && irq_en_q && !standby |=> conv_end_irq)
        else $error("Interrupt missing while enabled.");
    // Scan mode keeps converting after each result unless software stops it.
    a_scan_keeps: assert property (@(posedge mclk) disable iff (clr)         // [RULE_10] [RULE_12]
        done && scan_q && !sw_stop |=> start_q && state_q == ST_START)
        else $error("Scan stopped on its own.");
    // The scan position never runs past the selected channel count.
    a_pos_group: assert property (@(posedge mclk) disable iff (clr)          // [RULE_15]
        scan_q && state_q == ST_WAIT |-> pos_q <= chsel_q[1:0])
        else $error("Scan position beyond the selected count.");
    // With the trigger disabled, only software may set the start bit.
    a_trig_ignored: assert property (@(posedge mclk) disable iff (clr)       // [RULE_17]
        !trig_en_q && !sw_start && !start_q |=> !start_q)
        else $error("Start set by a disabled trigger.");
    // Upper byte reads return the live register, never the holding byte.
    a_rdata_hi: assert property (@(posedge mclk) disable iff (srst)          // [RULE_18] [RULE_21]
        rd_hi |=> bus_rdata == $past(result_q[rd_idx][15:8]))
        else $error("Upper byte read returned wrong data.");
    // Lower byte reads return the holding byte, so a pair stays coherent.
    a_rdata_hold: assert property (@(posedge mclk) disable iff (srst)        // [RULE_19]
        rd_res && bus_req.addr[0] |=> bus_rdata == $past(hold_q))
        else $error("Lower byte read bypassed the holding byte.");
    // The first conversion of a run gets the long slow budget.
    a_budget_first: assert property (@(posedge mclk) disable iff (clr)       // [RULE_14]
        state_q == ST_START && first_q && !speed_q && !sw_stop |=> tmr_q == `ADCSQ_FIRST_SLOW - 9'd1)
        else $error("First conversion budget wrong.");
    // Later scan conversions get the fixed slow budget.
    a_budget_next: assert property (@(posedge mclk) disable iff (clr)        // [RULE_23]
        state_q == ST_START && !first_q && !speed_q && !sw_stop |=> tmr_q == `ADCSQ_NEXT_SLOW - 9'd1)
        else $error("Scan conversion budget wrong.");
    // Each done strobe lands, packed, in the register of its position.
    a_result_pack: assert property (@(posedge mclk) disable iff (clr)        // [RULE_01] [RULE_03]
        done |=> result_q[$past(reg_idx)] == {$past(core_rsp.result), 6'h00})
        else $error("Result not stored in its register.");
    // The core start is a single-cycle pulse; a held start would restart it.
    a_start_pulse: assert property (@(posedge mclk) disable iff (clr)        // [RULE_24]
        cmd_q.start |=> !cmd_q.start)
        else $error("Core start held longer than one cycle.");
endmodule : adcsq_ctrl

// File: adcsq_defines.svh
// Register offsets, field positions, reset values and timing counts of the converter controller.
`ifndef ADCSQ_DEFINES_SVH
`define ADCSQ_DEFINES_SVH

// ----------------------------------------------------------------------
// Byte offsets on the internal 8-bit bus
// ----------------------------------------------------------------------
`define ADCSQ_OFF_RESULT_A_HI 4'h0
`define ADCSQ_OFF_RESULT_A_LO 4'h1
`define ADCSQ_OFF_RESULT_B_HI 4'h2
`define ADCSQ_OFF_RESULT_B_LO 4'h3
`define ADCSQ_OFF_RESULT_C_HI 4'h4
`define ADCSQ_OFF_RESULT_C_LO 4'h5
`define ADCSQ_OFF_RESULT_D_HI 4'h6
`define ADCSQ_OFF_RESULT_D_LO 4'h7
`define ADCSQ_OFF_CSR         4'h8
`define ADCSQ_OFF_TRIG        4'h9

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define ADCSQ_CSR_END    7
`define ADCSQ_CSR_IE     6
`define ADCSQ_CSR_START  5
`define ADCSQ_CSR_SCAN   4
`define ADCSQ_CSR_SPEED  3
`define ADCSQ_CSR_GROUP  2
`define ADCSQ_TRIG_EN    7
`define ADCSQ_CSR_RESET  8'h00
`define ADCSQ_TRIG_RESET 8'h7F
`define ADCSQ_TRIG_ONES  8'h7F
`define ADCSQ_RES_RESET  16'h0000

// ----------------------------------------------------------------------
// Conversion times in states (one state is one mclk cycle)
// ----------------------------------------------------------------------
`define ADCSQ_FIRST_SLOW 9'd266
`define ADCSQ_FIRST_FAST 9'd134
`define ADCSQ_NEXT_SLOW  9'd256
`define ADCSQ_NEXT_FAST  9'd128

`endif

// File: adcsq_pkg.sv
// Types shared by the converter controller.
package adcsq_pkg;
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [3:0] addr;
        logic [7:0] wdata;
    } adcsq_bus_req_t;

    typedef struct packed {
        logic       start;
        logic [2:0] channel;
    } adcsq_core_cmd_t;

    typedef struct packed {
        logic       done;
        logic [9:0] result;
    } adcsq_core_rsp_t;
endpackage : adcsq_pkg

// File: adcsq_core_model.sv
// Behavioural model of the analog converter core that answers the controller.
module adcsq_core_model (
    input  wire logic                       mclk,
    input  wire logic                       srst,
    input  wire logic [7:0]                 delay,
    input  wire adcsq_pkg::adcsq_core_cmd_t core_cmd,
    output adcsq_pkg::adcsq_core_rsp_t      core_rsp
);
    import adcsq_pkg::*;
    logic [7:0] cnt_q;
    logic [2:0] ch_q;
    logic       busy_q;

    // A new start restarts the countdown, so a stopped scan leaves no stale answer.
    // Between strobes the result lines toggle, so a late sample never looks valid.
    always_ff @(posedge mclk) begin
        core_rsp.done   <= 1'b0;
        core_rsp.result <= ~core_rsp.result;
        if (srst) begin
            busy_q   <= 1'b0;
            cnt_q    <= 8'h00;
            ch_q     <= 3'h0;
            core_rsp <= '0;
        end else if (core_cmd.start) begin
            busy_q <= 1'b1;
            cnt_q  <= delay;
            ch_q   <= core_cmd.channel;
        end else if (busy_q && cnt_q <= 8'h01) begin
            busy_q          <= 1'b0;
            core_rsp.done   <= 1'b1;
            core_rsp.result <= {ch_q, ~ch_q, ch_q, 1'b1};
        end else if (busy_q) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end
endmodule : adcsq_core_model

// File: adcsq_ctrl_tb_top.sv
// Self-checking bench of the converter controller with its core model.
`include "adcsq_defines.svh"
module adcsq_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import adcsq_pkg::*;
    logic            mclk, srst, standby, ext_trigger_n, conv_end_irq;
    logic [7:0]      bus_rdata, delay, rd_q;
    adcsq_bus_req_t  bus_req;
    adcsq_core_cmd_t core_cmd;
    adcsq_core_rsp_t core_rsp;
    logic [2:0]      starts[$];
    int              err_count, cmp_count, cycles, n;

    adcsq_ctrl i_dut (.mclk(mclk), .srst(srst), .standby(standby), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .ext_trigger_n(ext_trigger_n), .core_cmd(core_cmd),
        .core_rsp(core_rsp), .conv_end_irq(conv_end_irq));
    adcsq_core_model i_core (.mclk(mclk), .srst(srst), .delay(delay), .core_cmd(core_cmd),
        .core_rsp(core_rsp));

    // ----------------------------------------------------------------
    // Clock, watchdog and core start log
    // ----------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // The ceiling is far above the several hundred cycles the tests need.
    always @(posedge mclk) begin
        cycles++;
        if (core_cmd.start === 1'b1) starts.push_back(core_cmd.channel);
        if (cycles == 20000) begin
            err_count++;
            end_sim();
        end
    end

    // ----------------------------------------------------------------
    // Bus access and checking tasks
    // ----------------------------------------------------------------
    // Read data is registered, so it is sampled just after the edge that takes the read.
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus_req <= '{rd: !w, wr: w, addr: a, wdata: d};
        @(posedge mclk);
        bus_req <= '0;
        #1 rd_q = bus_rdata;
    endtask : bus
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", s, e, g);
        end
    endtask : chk
    task automatic rdchk(input string s, input logic [3:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(s, e, rd_q);
    endtask : rdchk
    task automatic wait_irq();
        for (int i = 0; i < 400 && conv_end_irq !== 1'b1; i++) begin
            @(posedge mclk);
            #1;
        end
    endtask : wait_irq
    function automatic logic [9:0] res(input logic [2:0] c);
        return {c, ~c, c, 1'b1};
    endfunction : res
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    // Main sequence: reset, single mode, masking, trigger, scan, standby.
    initial begin
        srst = 1'b1; standby = 1'b0; ext_trigger_n = 1'b1; delay = 8'd40; bus_req = '0;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        rdchk("csr", `ADCSQ_OFF_CSR, 8'h00);
        rdchk("trig", `ADCSQ_OFF_TRIG, 8'h7F);
        bus(1'b1, `ADCSQ_OFF_TRIG, 8'hFF);
        rdchk("trig_en", `ADCSQ_OFF_TRIG, 8'hFF);
        $display("test reset done");
        for (int c = 0; c < 8; c++) begin
            logic [7:0] csr;
            logic [9:0] old, r;
            logic [3:0] a;
            csr = {4'h6, c[0], c[2:0]};
            old = (c < 4) ? 10'h000 : res(3'(c - 4));
            r = res(3'(c));
            a = {1'b0, c[1:0], 1'b0};
            rdchk("res_hi_old", a, old[9:2]);
            starts.delete();
            bus(1'b1, `ADCSQ_OFF_CSR, csr);
            rdchk("csr_busy", `ADCSQ_OFF_CSR, csr);
            wait_irq();
            chk("irq", 8'h01, {7'h00, conv_end_irq});
            chk("channel", {5'h00, 3'(c)}, {5'h00, starts[0]});
            rdchk("res_lo_held", a + 4'h1, {old[1:0], 6'h00});
            bus(1'b1, `ADCSQ_OFF_CSR, csr & 8'h5F);
            rdchk("csr_end", `ADCSQ_OFF_CSR, csr ^ 8'hA0);
            bus(1'b1, `ADCSQ_OFF_CSR, csr & 8'h5F);
            rdchk("csr_clr", `ADCSQ_OFF_CSR, csr & 8'h5F);
            chk("irq_clr", 8'h00, {7'h00, conv_end_irq});
            rdchk("res_hi", a, r[9:2]);
            rdchk("res_lo", a + 4'h1, {r[1:0], 6'h00});
        end
        $display("test single done");
        bus(1'b1, `ADCSQ_OFF_CSR, 8'h23);
        repeat (60) @(posedge mclk);
        chk("irq_masked", 8'h00, {7'h00, conv_end_irq});
        rdchk("csr_masked", `ADCSQ_OFF_CSR, 8'h83);
        bus(1'b1, `ADCSQ_OFF_CSR, 8'h00);
        starts.delete();
        @(posedge mclk) ext_trigger_n <= 1'b0;
        rdchk("csr_trig", `ADCSQ_OFF_CSR, 8'h20);
        ext_trigger_n <= 1'b1;
        repeat (60) @(posedge mclk);
        chk("trig_starts", 8'h01, 8'(starts.size()));
        bus(1'b1, `ADCSQ_OFF_TRIG, 8'h00);
        rdchk("trig_off", `ADCSQ_OFF_TRIG, 8'h7F);
        starts.delete();
        @(posedge mclk) ext_trigger_n <= 1'b0;
        repeat (60) @(posedge mclk);
        ext_trigger_n <= 1'b1;
        chk("trig_ignored", 8'h00, 8'(starts.size()));
        $display("test trigger done");
        delay <= 8'h02;
        rdchk("csr_end2", `ADCSQ_OFF_CSR, 8'h80);
        bus(1'b1, `ADCSQ_OFF_CSR, 8'h00);
        starts.delete();
        bus(1'b1, `ADCSQ_OFF_CSR, 8'h76);
        wait_irq();
        for (int i = 0; i < 3; i++) chk("scan_ch", 8'(4 + i), {5'h00, starts[i]});
        rdchk("csr_scan", `ADCSQ_OFF_CSR, 8'hF6);
        rdchk("res_b_hi", `ADCSQ_OFF_RESULT_B_HI, 8'hAA);
        bus(1'b1, `ADCSQ_OFF_CSR, 8'h56);
        repeat (4) @(posedge mclk);
        n = starts.size();
        repeat (40) @(posedge mclk);
        chk("scan_stop", 8'(n), 8'(starts.size()));
        starts.delete();
        bus(1'b1, `ADCSQ_OFF_CSR, 8'h76);
        wait_irq();
        chk("scan_restart", 8'h04, {5'h00, starts[0]});
        $display("test scan done");
        @(posedge mclk) standby <= 1'b1;
        repeat (2) @(posedge mclk);
        standby <= 1'b0;
        bus(1'b1, `ADCSQ_OFF_RESULT_A_HI, 8'hFF);
        rdchk("sb_csr", `ADCSQ_OFF_CSR, 8'h00);
        rdchk("sb_trig", `ADCSQ_OFF_TRIG, 8'h7F);
        rdchk("sb_res_hi", `ADCSQ_OFF_RESULT_A_HI, 8'h00);
        rdchk("sb_res_lo", `ADCSQ_OFF_RESULT_A_LO, 8'h00);
        rdchk("unmapped", 4'hA, 8'h00);
        $display("test standby done");
        end_sim();
    end
endmodule : adcsq_ctrl_tb_top
